// ---- testbench/sspe_tb_top.sv ----
`timescale 1ns/100ps
`include "sspe_cfg.svh"
module sspe_tb_top
	import sspe_pkg::*;
();
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic tx_req, rx_req, irq, m_lock, m_fswe;
	logic [7:0] paddr, rnd, m_ctrl;
	logic [7:0] codes [4];
	logic [31:0] pwdata, prdata;
	sspe_err_t err_evt;
	sspe_ctrl_t serial_ctrl;
	logic [1:0] irq_pending_flag, m_pend, m_held;
	logic [2:0] pin_serial, m_err, m_irqs, m_irqe, m_pmode;
	logic [4:0] m_sel [3];
	int miscompares, n_compared;

	sspe_top sspe_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.tx_data_empty_request(tx_req), .rx_data_full_request(rx_req),
		.err_evt(err_evt), .serial_ctrl(serial_ctrl),
		.irq_pending_flag(irq_pending_flag), .pin_serial(pin_serial),
		.irq(irq));

	// ============================================================
	// Clock, watchdog and verdict.
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	// The whole run needs well under a thousand cycles; this is ample.
	initial begin
		#20000;
		miscompares++;
		$display("Error at %0t: timeout", $time);
		tally_and_finish();
	end

	task automatic tally_and_finish();
		$display("compared %0d, mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// ============================================================
	// Reference model of the register file.
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction

	function automatic logic [31:0] m_rd(input logic [7:0] a);
		case (a)
		`SSPE_A_CTRL: return 32'(m_ctrl);
		`SSPE_A_STAT: return 32'({m_err, 3'h0});
		`SSPE_A_PEND: return 32'({m_held, 2'h0, m_pend});
		`SSPE_A_PMODE: return 32'(m_pmode);
		`SSPE_A_WPROT: return 32'({m_lock, m_fswe, 6'h00});
		`SSPE_A_PFS0: return 32'(m_sel[0]);
		`SSPE_A_PFS1: return 32'(m_sel[1]);
		`SSPE_A_PFS2: return 32'(m_sel[2]);
		`SSPE_A_IRQS: return 32'(m_irqs);
		`SSPE_A_IRQE: return 32'(m_irqe);
		default: return 32'h0;
		endcase
	endfunction

	// A held request refills its flag only while the source is enabled.
	task automatic m_wr(input logic [7:0] a, input logic [31:0] d);
		case (a)
		`SSPE_A_CTRL: m_ctrl = d[7:0];
		`SSPE_A_STAT: m_err = m_err & d[5:3];
		`SSPE_A_PEND: for (int i = 0; i < 2; i++) begin
			if (!d[i]) begin
				m_pend[i] = m_held[i] & m_ctrl[7 - i];
				m_held[i] = 1'b0;
			end
		end
		`SSPE_A_PMODE: m_pmode = d[2:0];
		`SSPE_A_WPROT: begin
			if (!m_lock)
				m_fswe = d[6];
			m_lock = d[7];
		end
		`SSPE_A_PFS0: if (m_fswe) m_sel[0] = d[4:0];
		`SSPE_A_PFS1: if (m_fswe) m_sel[1] = d[4:0];
		`SSPE_A_PFS2: if (m_fswe) m_sel[2] = d[4:0];
		`SSPE_A_IRQC: m_irqs = m_irqs & ~d[2:0];
		`SSPE_A_IRQE: m_irqe = d[2:0];
		default: ;
		endcase
	endtask

	// ============================================================
	// Comparisons.
	task automatic cmp_rd(input logic [32:0] got, input logic [32:0] exp);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("Error at %0t: read %h, expected %h", $time, got, exp);
		end
	endtask

	task automatic cmp_out(input logic [13:0] got, input logic [13:0] exp);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("Error at %0t: pins %h, expected %h", $time, got, exp);
		end
	endtask

	// ============================================================
	// Bus and event drivers.
	// Pready is sampled at the rising edge that ends the access; read
	// data is taken at that same edge, and only then is the request
	// released, so the slave always sees a stable request.
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
		m_wr(a, d);
	endtask

	task automatic rd(input logic [7:0] a);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 32'h0, r, e);
		cmp_rd({e, r}, {a > 8'h28 || a[1:0] != 2'h0, m_rd(a)});
	endtask

	// Outputs lag the registers by one cycle, so two edges are allowed.
	task automatic chk();
		logic [2:0] ps;
		repeat (2) @(posedge pclk);
		@(negedge pclk);
		for (int i = 0; i < 3; i++)
			ps[i] = m_pmode[i] && m_sel[i] === `SSPE_C_SERIAL;
		cmp_out({serial_ctrl, irq_pending_flag, pin_serial, irq},
			{m_ctrl, m_pend, ps, |(m_irqs & m_irqe)});
	endtask

	// One-cycle event pulses; bit 0 of q is transmit, bit 1 receive.
	task automatic ev(input logic [1:0] q, input logic [2:0] e);
		@(posedge pclk);
		tx_req <= q[0];
		rx_req <= q[1];
		err_evt <= e;
		@(posedge pclk);
		tx_req <= 1'b0;
		rx_req <= 1'b0;
		err_evt <= 3'h0;
		for (int i = 0; i < 2; i++) begin
			if (q[i] && m_ctrl[7 - i]) begin
				if (m_pend[i])
					m_held[i] = 1'b1;
				else begin
					m_pend[i] = 1'b1;
					m_irqs[i] = 1'b1;
				end
			end
		end
		if (e != 3'h0) begin
			m_err = m_err | e;
			m_irqs[2] = 1'b1;
		end
	endtask

	// ============================================================
	// Test sequence.
	initial begin
		{presetn, psel, penable, pwrite, tx_req, rx_req} = 6'h00;
		{paddr, pwdata, err_evt} = 43'h0;
		{m_pend, m_held, m_err, m_irqs, m_irqe, m_pmode, m_fswe} = 17'h0;
		m_sel = '{default: 5'h00};
		m_ctrl = `SSPE_R_CTRL;
		m_lock = 1'b1;
		{miscompares, n_compared} = 64'h0;
		rnd = lfsr(8'h3C);
		codes = '{rnd, `SSPE_C_TX_ON, `SSPE_C_TRX_ON, `SSPE_C_OFF};
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		for (int a = 0; a <= 'h28; a += 4)
			if (a != 'h24) rd(8'(a));
		chk();
		$display("reset test done");
		foreach (codes[i]) begin
			wr(`SSPE_A_CTRL, 32'(codes[i]));
			rd(`SSPE_A_CTRL);
			chk();
		end
		$display("control code test done");
		wr(`SSPE_A_PFS0, 32'h0A);
		rd(`SSPE_A_PFS0);
		wr(`SSPE_A_WPROT, 32'hC0);
		rd(`SSPE_A_WPROT);
		wr(`SSPE_A_WPROT, 32'h00);
		wr(`SSPE_A_WPROT, 32'h40);
		rd(`SSPE_A_WPROT);
		for (int i = 0; i < 3; i++) begin
			wr(`SSPE_A_PFS0 + 8'(4 * i), 32'h0A);
			rd(`SSPE_A_PFS0 + 8'(4 * i));
		end
		wr(`SSPE_A_WPROT, 32'h00);
		wr(`SSPE_A_WPROT, 32'h80);
		wr(`SSPE_A_PFS1, 32'h1F);
		rd(`SSPE_A_PFS1);
		wr(`SSPE_A_PMODE, 32'h7);
		chk();
		wr(`SSPE_A_PMODE, 32'h5);
		chk();
		wr(`SSPE_A_WPROT, 32'h00);
		wr(`SSPE_A_WPROT, 32'h40);
		rnd = lfsr(rnd);
		wr(`SSPE_A_PFS1, 32'(rnd) | 32'hFFFF_FF00);
		rd(`SSPE_A_PFS1);
		wr(`SSPE_A_PMODE, 32'h7);
		chk();
		$display("pin select test done");
		wr(`SSPE_A_IRQE, 32'h7);
		wr(`SSPE_A_CTRL, 32'(`SSPE_C_TX_ON));
		ev(2'h1, 3'h0);
		chk();
		ev(2'h1, 3'h0);
		rd(`SSPE_A_PEND);
		wr(`SSPE_A_PEND, 32'h0);
		rd(`SSPE_A_PEND);
		chk();
		wr(`SSPE_A_IRQC, 32'h7);
		rd(`SSPE_A_IRQS);
		wr(`SSPE_A_CTRL, 32'(`SSPE_C_TRX_ON));
		ev(2'h2, 3'h0);
		ev(2'h2, 3'h0);
		rd(`SSPE_A_PEND);
		wr(`SSPE_A_CTRL, 32'(`SSPE_C_OFF));
		ev(2'h3, 3'h0);
		rd(`SSPE_A_CTRL);
		wr(`SSPE_A_PEND, 32'h0);
		rd(`SSPE_A_PEND);
		rd(`SSPE_A_IRQS);
		chk();
		$display("pending test done");
		rnd = lfsr(rnd);
		ev(2'h0, rnd[2:0]);
		rd(`SSPE_A_STAT);
		ev(2'h0, 3'h7);
		wr(`SSPE_A_STAT, 32'h20);
		rd(`SSPE_A_STAT);
		wr(`SSPE_A_STAT, 32'h0);
		rd(`SSPE_A_STAT);
		rd(`SSPE_A_IRQS);
		chk();
		wr(`SSPE_A_IRQC, 32'h4);
		chk();
		$display("error flag test done");
		// Bring-up and shutdown in the order that software must keep.
		wr(`SSPE_A_CTRL, 32'(`SSPE_C_OFF));
		rd(`SSPE_A_CTRL);
		wr(`SSPE_A_PEND, 32'h0);
		rd(`SSPE_A_PEND);
		wr(`SSPE_A_PMODE, 32'h0);
		wr(`SSPE_A_WPROT, 32'h00);
		wr(`SSPE_A_WPROT, 32'h40);
		for (int i = 0; i < 3; i++)
			wr(`SSPE_A_PFS0 + 8'(4 * i), 32'h0A);
		wr(`SSPE_A_WPROT, 32'h00);
		wr(`SSPE_A_WPROT, 32'h80);
		wr(`SSPE_A_PMODE, 32'h7);
		wr(`SSPE_A_CTRL, 32'(`SSPE_C_TRX_ON));
		rd(`SSPE_A_CTRL);
		ev(2'h3, 3'h0);
		chk();
		wr(`SSPE_A_CTRL, 32'(`SSPE_C_OFF));
		rd(`SSPE_A_CTRL);
		wr(`SSPE_A_PMODE, 32'h0);
		chk();
		wr(`SSPE_A_PEND, 32'h0);
		rd(`SSPE_A_PEND);
		$display("bring-up test done");
		wr(8'h40, 32'hFF);
		rd(8'h40);
		rd(8'h2C);
		rd(`SSPE_A_CTRL);
		$display("unmapped test done");
		tally_and_finish();
	end
endmodule // sspe_tb_top

// ---- verilog/sspe_cfg.svh ----
`ifndef SSPE_CFG_SVH
`define SSPE_CFG_SVH
// ============================================================
// Register byte offsets on the APB.
`define SSPE_A_CTRL 8'h00
`define SSPE_A_STAT 8'h04
`define SSPE_A_PEND 8'h08
`define SSPE_A_PMODE 8'h0C
`define SSPE_A_WPROT 8'h10
`define SSPE_A_PFS0 8'h14
`define SSPE_A_PFS1 8'h18
`define SSPE_A_PFS2 8'h1C
`define SSPE_A_IRQS 8'h20
`define SSPE_A_IRQC 8'h24
`define SSPE_A_IRQE 8'h28
// ============================================================
// Field positions.
`define SSPE_B_OVR 5
`define SSPE_B_FRM 4
`define SSPE_B_PAR 3
`define SSPE_B_LOCK 7
`define SSPE_B_FSWE 6
// ============================================================
// Reset values and codes.
`define SSPE_R_CTRL 8'h00
`define SSPE_R_WPROT 8'h80
`define SSPE_C_TX_ON 8'hA1
`define SSPE_C_TRX_ON 8'hF1
`define SSPE_C_OFF 8'h01
`define SSPE_C_SERIAL 5'h0A
`define SSPE_N_PINS 3
`endif

// ---- verilog/sspe_irq_hold.sv ----
`timescale 1ns/100ps
`include "sspe_cfg.svh"
// One interrupt source: pending flag plus one held request behind it.
module sspe_irq_hold (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic req,
	input wire logic clr,
	input wire logic drop,
	output logic pend_q,
	output logic held_q
);
	// ============================================================
	// A request landing on a set flag is kept and refills the flag
	// at its clear; a new request in the clear cycle wins the flag.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pend_q <= 1'b0;
			held_q <= 1'b0;
		end else if (clr) begin
			pend_q <= req | (held_q & ~drop);
			held_q <= req & held_q & ~drop;
		end else if (req) begin
			if (pend_q) begin
				held_q <= 1'b1;
			end else begin
				pend_q <= 1'b1;
			end
		end
	end
endmodule // sspe_irq_hold

// ---- verilog/sspe_pkg.sv ----
package sspe_pkg;
	// Serial control register layout, bit 7 first.
	typedef struct packed {
		logic tx_irq_enable_bit;
		logic rx_irq_enable_bit;
		logic transmit_enable_bit;
		logic receive_enable_bit;
		logic spare;
		logic tx_end_irq_enable_bit;
		logic [1:0] clk_sel;
	} sspe_ctrl_t;
	// Serial error events from the shifter.
	typedef struct packed {
		logic overrun;
		logic framing;
		logic parity;
	} sspe_err_t;
endpackage

// ---- verilog/sspe_top.sv ----
// The address map and the APB slave port were decided locally.
`timescale 1ns/100ps
`include "sspe_cfg.svh"
// Notes on behaviour
// - A1h enables transmit and its interrupt
// - F1h enables transmit, receive, both interrupts
// - 01h disables everything, keeps internal clock
// - Request on set flag held, refills later
// - Port mode bit: 0 port, 1 peripheral
// - Lock bit guards the select write enable
// - Select registers writable only when enabled
// - Five-bit selector, 0Ah routes to serial
module sspe_top
	import sspe_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic tx_data_empty_request,
	input wire logic rx_data_full_request,
	input wire sspe_err_t err_evt,
	output sspe_ctrl_t serial_ctrl,
	output logic [1:0] irq_pending_flag,
	output logic [2:0] pin_serial,
	output logic irq
);
	// ============================================================
	// Register state.
	sspe_ctrl_t ctrl_q;
	sspe_err_t err_q;
	logic [2:0] pmode_q;
	logic lock_q;
	logic fswe_q;
	logic [4:0] pfs_q [`SSPE_N_PINS];
	logic [2:0] ists_q;
	logic [2:0] ien_q;
	logic [1:0] pend;
	logic [1:0] held;
	logic [1:0] req;
	logic [1:0] pclr;
	logic [1:0] ien_bits;
	logic wr;
	logic setup;
	logic [31:0] rd_d;
	logic known;

	// Pin is routed to the serial unit only in peripheral mode
	// with the serial selector code.
	function automatic logic to_serial(input logic pm,
			input logic [4:0] sel);
		to_serial = pm && (sel == `SSPE_C_SERIAL);
	endfunction

	// Address decode, shared by read mux and error answer.
	function automatic logic hit(input logic [7:0] a,
			input logic [7:0] r);
		hit = (a == r);
	endfunction

	// ============================================================
	// APB handshake: one wait-free access cycle after setup.
	assign setup = psel && !penable;
	assign wr = psel && penable && pwrite && pready;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
		end else begin
			pready <= setup;
		end
	end

	// Read data and the error answer are fetched in setup, so the
	// access cycle presents them straight from flops.
	always_comb begin
		rd_d = 32'h0000_0000;
		known = 1'b1;
		if (hit(paddr, `SSPE_A_CTRL)) begin
			rd_d[7:0] = ctrl_q;
		end else if (hit(paddr, `SSPE_A_STAT)) begin
			rd_d[`SSPE_B_OVR] = err_q.overrun;
			rd_d[`SSPE_B_FRM] = err_q.framing;
			rd_d[`SSPE_B_PAR] = err_q.parity;
		end else if (hit(paddr, `SSPE_A_PEND)) begin
			rd_d[1:0] = pend;
			rd_d[5:4] = held;
		end else if (hit(paddr, `SSPE_A_PMODE)) begin
			rd_d[2:0] = pmode_q;
		end else if (hit(paddr, `SSPE_A_WPROT)) begin
			rd_d[`SSPE_B_LOCK] = lock_q;
			rd_d[`SSPE_B_FSWE] = fswe_q;
		end else if (hit(paddr, `SSPE_A_PFS0)) begin
			rd_d[4:0] = pfs_q[0];
		end else if (hit(paddr, `SSPE_A_PFS1)) begin
			rd_d[4:0] = pfs_q[1];
		end else if (hit(paddr, `SSPE_A_PFS2)) begin
			rd_d[4:0] = pfs_q[2];
		end else if (hit(paddr, `SSPE_A_IRQS)) begin
			rd_d[2:0] = ists_q;
		end else if (hit(paddr, `SSPE_A_IRQE)) begin
			rd_d[2:0] = ien_q;
		end else if (!hit(paddr, `SSPE_A_IRQC)) begin
			known = 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (setup) begin
			prdata <= pwrite ? 32'h0000_0000 : rd_d;
			pslverr <= !known;
		end else begin
			pslverr <= 1'b0;
		end
	end

	// ============================================================
	// Serial control register. Any code is stored whole, so the
	// enabling and disabling codes give exactly their bit sets.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= `SSPE_R_CTRL;
		end else if (wr && hit(paddr, `SSPE_A_CTRL)) begin
			ctrl_q <= pwdata[7:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			serial_ctrl <= `SSPE_R_CTRL;
		end else begin
			serial_ctrl <= ctrl_q;
		end
	end

	// ============================================================
	// Error flags: set by the shifter, cleared by writing 0;
	// writing 1 leaves a flag alone and a new error wins.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			err_q <= 3'b000;
		end else if (wr && hit(paddr, `SSPE_A_STAT)) begin
			err_q.overrun <= err_evt.overrun |
				(err_q.overrun & pwdata[`SSPE_B_OVR]);
			err_q.framing <= err_evt.framing |
				(err_q.framing & pwdata[`SSPE_B_FRM]);
			err_q.parity <= err_evt.parity |
				(err_q.parity & pwdata[`SSPE_B_PAR]);
		end else begin
			err_q <= err_q | err_evt;
		end
	end

	// ============================================================
	// Pending flags with held requests, one per source. Writing 0
	// to a flag clears it; a held request is dropped when its
	// interrupt enable is already off, which is how software
	// flushes stale requests before starting.
	assign req[0] = tx_data_empty_request && ctrl_q.tx_irq_enable_bit;
	assign req[1] = rx_data_full_request && ctrl_q.rx_irq_enable_bit;
	assign ien_bits = {ctrl_q.rx_irq_enable_bit,
		ctrl_q.tx_irq_enable_bit};

	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_src
			assign pclr[g] = wr && hit(paddr, `SSPE_A_PEND) &&
				!pwdata[g];
			sspe_irq_hold u_hold (
				.pclk(pclk),
				.presetn(presetn),
				.req(req[g]),
				.clr(pclr[g]),
				.drop(!ien_bits[g]),
				.pend_q(pend[g]),
				.held_q(held[g])
			);
		end
	endgenerate

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_pending_flag <= 2'b00;
		end else begin
			irq_pending_flag <= pend;
		end
	end

	// ============================================================
	// Pin write protection. Lock starts set, so the select enable
	// cannot be opened until software drops the lock first.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lock_q <= 1'(`SSPE_R_WPROT >> `SSPE_B_LOCK);
			fswe_q <= 1'b0;
		end else if (wr && hit(paddr, `SSPE_A_WPROT)) begin
			lock_q <= pwdata[`SSPE_B_LOCK];
			if (!lock_q) begin
				fswe_q <= pwdata[`SSPE_B_FSWE];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pmode_q <= 3'b000;
		end else if (wr && hit(paddr, `SSPE_A_PMODE)) begin
			pmode_q <= pwdata[2:0];
		end
	end

	// Selectors accept writes only behind the open enable. The
	// block does not refuse writes in peripheral mode; glitch
	// avoidance there is left to software.
	generate
		for (g = 0; g < `SSPE_N_PINS; g++) begin : g_pin
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					pfs_q[g] <= 5'h00;
				end else if (wr && fswe_q && hit(paddr,
						8'(`SSPE_A_PFS0 + 4 * g))) begin
					pfs_q[g] <= pwdata[4:0];
				end
			end
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					pin_serial[g] <= 1'b0;
				end else begin
					pin_serial[g] <= to_serial(pmode_q[g],
						pfs_q[g]);
				end
			end
		end
	endgenerate

	// ============================================================
	// Interrupt status: sticky on new pending flags and errors,
	// write-one-to-clear, and a set in the clear cycle wins.
	logic [1:0] pend_p;
	logic [2:0] ev;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pend_p <= 2'b00;
		end else begin
			pend_p <= pend;
		end
	end
	assign ev = {|err_evt, pend & ~pend_p};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ists_q <= 3'b000;
		end else if (wr && hit(paddr, `SSPE_A_IRQC)) begin
			ists_q <= (ists_q & ~pwdata[2:0]) | ev;
		end else begin
			ists_q <= ists_q | ev;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ien_q <= 3'b000;
		end else if (wr && hit(paddr, `SSPE_A_IRQE)) begin
			ien_q <= pwdata[2:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(ists_q & ien_q);
		end
	end

	// ============================================================
	// Checks.
	a_ctrl_readback: assert property (@(posedge pclk)
		disable iff (!presetn)
		wr && hit(paddr, `SSPE_A_CTRL) |=> ctrl_q == $past(pwdata[7:0])
		##1 serial_ctrl == $past(pwdata[7:0], 2))
		else $error("control register lost written value");

	a_code_tx_on: assert property (@(posedge pclk)
		disable iff (!presetn)
		wr && hit(paddr, `SSPE_A_CTRL) && pwdata[7:0] == 8'hA1
		|=> ctrl_q.tx_irq_enable_bit && ctrl_q.transmit_enable_bit
		&& !ctrl_q.receive_enable_bit && ctrl_q.clk_sel == 2'h1)
		else $error("transmit enable code misdecoded");

	a_code_trx_on: assert property (@(posedge pclk)
		disable iff (!presetn)
		wr && hit(paddr, `SSPE_A_CTRL) && pwdata[7:0] == 8'hF1
		|=> ctrl_q.rx_irq_enable_bit && ctrl_q.receive_enable_bit
		&& ctrl_q.transmit_enable_bit)
		else $error("transfer enable code misdecoded");

	a_code_off: assert property (@(posedge pclk)
		disable iff (!presetn)
		wr && hit(paddr, `SSPE_A_CTRL) && pwdata[7:0] == 8'h01
		|=> ctrl_q[7:2] == 6'h00 && ctrl_q.clk_sel == 2'h1)
		else $error("disable code left something on");

	a_hold_refill: assert property (@(posedge pclk)
		disable iff (!presetn)
		pclr[0] && held[0] && ctrl_q.tx_irq_enable_bit && !req[0]
		|=> pend[0] && !held[0])
		else $error("held request did not refill flag");

	a_fswe_locked: assert property (@(posedge pclk)
		disable iff (!presetn)
		lock_q |=> $stable(fswe_q))
		else $error("select enable changed while locked");

	a_pfs_locked: assert property (@(posedge pclk)
		disable iff (!presetn)
		!fswe_q |=> $stable(pfs_q[0]) && $stable(pfs_q[1])
		&& $stable(pfs_q[2]))
		else $error("selector written while protected");

	a_route_map: assert property (@(posedge pclk)
		disable iff (!presetn)
		pmode_q[0] && pfs_q[0] == 5'h0A ##1 $stable(pmode_q[0])
		&& $stable(pfs_q[0]) |-> pin_serial[0])
		else $error("pin not routed to serial unit");

	a_err_clear: assert property (@(posedge pclk)
		disable iff (!presetn)
		wr && hit(paddr, `SSPE_A_STAT) && !pwdata[`SSPE_B_OVR]
		&& !err_evt.overrun |=> !err_q.overrun)
		else $error("overrun flag not cleared by zero");
endmodule // sspe_top
